// *** hdl/vic_defs.svh ***
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH

// ==========================================================================
// Sizes
// ==========================================================================
`define VIC_NUM_SRC            28
`define VIC_SRC_W              5
`define VIC_LVL_W              3
`define VIC_NUM_LVL            8
`define VIC_BASE_W             16
`define VIC_EV_W               3

// ==========================================================================
// Register byte addresses
// ==========================================================================
`define VIC_ADDR_BASE          32'hFFFF0014
`define VIC_ADDR_VEC           32'hFFFF001C
`define VIC_ADDR_PRIO_FIRST    32'hFFFF0020
`define VIC_ADDR_PRIO_SECOND   32'hFFFF0024
`define VIC_ADDR_CFG           32'hFFFF0030
`define VIC_ADDR_EOI           32'hFFFF0034
`define VIC_ADDR_STATUS        32'hFFFF0038
`define VIC_ADDR_MASK          32'hFFFF003C

// ==========================================================================
// Field layout and reset values
// ==========================================================================
`define VIC_VEC_BASE_LSB       7
`define VIC_VEC_ID_LSB         2
`define VIC_FIELD_STRIDE       4
`define VIC_FIRST_SRC_OFS      1
`define VIC_SECOND_SRC_OFS     9
`define VIC_FIRST_FIELD_MASK   32'h77777770
`define VIC_SECOND_FIELD_MASK  32'h77777777
`define VIC_PRIO_RESET         32'h00000000
`define VIC_BASE_RESET         16'h0000
`define VIC_LAST_SRC_ID        5'h1B
`define VIC_TIMER_TWO_SRC      5'h04
`define VIC_CFG_EN_BIT         0
`define VIC_EV_WIN             0
`define VIC_EV_ACK             1
`define VIC_EV_UNDER           2

`endif

// *** hdl/vic_pkg.sv ***
`default_nettype none
`include "vic_defs.svh"

package vic_pkg;

	typedef logic [`VIC_LVL_W-1:0] level_t;
	typedef logic [`VIC_SRC_W-1:0] src_t;

	typedef enum logic [3:0] {
		SEL_NONE,
		SEL_BASE,
		SEL_VEC,
		SEL_PRIO_FIRST,
		SEL_PRIO_SECOND,
		SEL_CFG,
		SEL_EOI,
		SEL_STATUS,
		SEL_MASK
	} reg_sel_t;

	typedef struct packed {
		logic [`VIC_NUM_LVL-1:0] in_service;
	} nest_state_t;

	typedef struct packed {
		logic                    cfg_en;
		logic [`VIC_BASE_W-1:0]  vec_base;
		logic [31:0]             prio_first;
		logic [31:0]             prio_second;
		logic [`VIC_EV_W-1:0]    status;
		logic [`VIC_EV_W-1:0]    mask;
		logic                    dp_write;
		reg_sel_t                dp_sel;
		logic [31:0]             hrdata;
		logic                    irq_req;
		logic                    irq_line;
		logic                    elig_d;
	} vic_state_t;

endpackage

`default_nettype wire

// *** hdl/vic_sel_if.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "vic_defs.svh"

interface vic_sel_if;
	logic [`VIC_NUM_SRC-1:0]                active;
	vic_pkg::level_t [`VIC_NUM_SRC-1:0]     levels;
	logic                                   win_valid;
	vic_pkg::src_t                          win_id;
	vic_pkg::level_t                        win_level;
	logic                                   push;
	vic_pkg::level_t                        push_level;
	logic                                   pop;
	logic                                   svc_busy;
	vic_pkg::level_t                        svc_level;

	modport sel (input active, input levels, output win_valid, output win_id, output win_level);
	modport nest (input push, input push_level, input pop, output svc_busy, output svc_level);
	modport core (output active, output levels, output push, output push_level, output pop,
		input win_valid, input win_id, input win_level, input svc_busy, input svc_level);
endinterface

`default_nettype wire

// *** hdl/vic_select.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "vic_defs.svh"

module vic_select (
	vic_sel_if.sel sel
);
	// Scanning downward with a non-strict compare lets the lowest number win a tie.
	always_comb begin
		sel.win_valid = 1'b0;
		sel.win_id    = '0;
		sel.win_level = '0;
		for (int i = `VIC_NUM_SRC - 1; i >= 0; i--) begin
			if (sel.active[i] && (!sel.win_valid || sel.levels[i] <= sel.win_level)) begin
				sel.win_valid = 1'b1;
				sel.win_id    = vic_pkg::src_t'(i);
				sel.win_level = sel.levels[i];
			end
		end
	end
endmodule

`default_nettype wire

// *** hdl/vic_nest.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "vic_defs.svh"

module vic_nest (
	input  wire logic  hclk,
	input  wire logic  hresetn,
	vic_sel_if.nest    nest
);
	vic_pkg::nest_state_t s_reg;
	vic_pkg::nest_state_t s_next;
	logic [`VIC_NUM_LVL-1:0] lowest;

	// One bit per level: a level can be in service once, so eight levels give eight nested handlers.
	always_comb begin
		lowest         = '0;
		nest.svc_level = '0;
		for (int i = `VIC_NUM_LVL - 1; i >= 0; i--) begin
			if (s_reg.in_service[i]) begin
				lowest         = '0;
				lowest[i]      = 1'b1;
				nest.svc_level = vic_pkg::level_t'(i);
			end
		end
		nest.svc_busy = |s_reg.in_service;
		s_next = s_reg;
		if (nest.pop)
			s_next.in_service = s_next.in_service & ~lowest;
		if (nest.push)
			s_next.in_service[nest.push_level] = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
endmodule

`default_nettype wire

// *** hdl/irq_vector_priority_unit.sv ***
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "vic_defs.svh"

module irq_vector_priority_unit (
	input  wire logic                            hclk,
	input  wire logic                            hresetn,
	input  wire logic                            hsel,
	input  wire logic [31:0]                     haddr,
	input  wire logic [1:0]                      htrans,
	input  wire logic                            hwrite,
	input  wire logic [2:0]                      hsize,
	input  wire logic [31:0]                     hwdata,
	input  wire logic                            hready,
	output logic                                 hreadyout,
	output logic                                 hresp,
	output logic [31:0]                          hrdata,
	input  wire logic [`VIC_NUM_SRC-1:0]         irq_source_active,
	input  wire logic [3*`VIC_NUM_SRC-1:0]       ext_priority_levels,
	output logic                                 irq_request,
	output logic                                 irq_interrupt
);
	// ======================================================================
	// State and wiring
	// ======================================================================
	vic_pkg::vic_state_t s_reg;
	vic_pkg::vic_state_t s_next;
	vic_sel_if           sel ();

	logic                          addr_ok;
	vic_pkg::reg_sel_t             addr_sel;
	logic                          eligible;
	logic [`VIC_EV_W-1:0]          events;
	logic [`VIC_EV_W-1:0]          rd_clear;
	logic                          vec_rd;
	logic [`VIC_NUM_SRC-1:0]       lose_err;
	logic [2:0]                    unused_size;
	logic                          stat_rd;
	logic                          mask_wr;

	vic_select u_select (
		.sel (sel)
	);

	vic_nest u_nest (
		.hclk    (hclk),
		.hresetn (hresetn),
		.nest    (sel)
	);

	function automatic vic_pkg::reg_sel_t decode(input logic [31:0] a);
		case (a)
			`VIC_ADDR_BASE:        decode = vic_pkg::SEL_BASE;
			`VIC_ADDR_VEC:         decode = vic_pkg::SEL_VEC;
			`VIC_ADDR_PRIO_FIRST:  decode = vic_pkg::SEL_PRIO_FIRST;
			`VIC_ADDR_PRIO_SECOND: decode = vic_pkg::SEL_PRIO_SECOND;
			`VIC_ADDR_CFG:         decode = vic_pkg::SEL_CFG;
			`VIC_ADDR_EOI:         decode = vic_pkg::SEL_EOI;
			`VIC_ADDR_STATUS:      decode = vic_pkg::SEL_STATUS;
			`VIC_ADDR_MASK:        decode = vic_pkg::SEL_MASK;
			default:               decode = vic_pkg::SEL_NONE;
		endcase
	endfunction

	// ======================================================================
	// Source levels
	// ======================================================================
	// Sources outside both priority registers, other than source 0 (fixed at
	// level 0), take their level from the neighbouring block through ext_priority_levels.
	for (genvar i = 0; i < `VIC_NUM_SRC; i++) begin : g_src
		if (i == 0) begin : g_fixed
			assign sel.levels[i] = '0;
		end else if (i > `VIC_FIRST_SRC_OFS && i <= `VIC_FIRST_SRC_OFS + 7) begin : g_first
			assign sel.levels[i] = s_reg.prio_first[`VIC_FIELD_STRIDE*(i-`VIC_FIRST_SRC_OFS)
				+: `VIC_LVL_W];
		end else if (i >= `VIC_SECOND_SRC_OFS && i <= `VIC_SECOND_SRC_OFS + 7) begin : g_second
			assign sel.levels[i] = s_reg.prio_second[`VIC_FIELD_STRIDE*(i-`VIC_SECOND_SRC_OFS)
				+: `VIC_LVL_W];
		end else begin : g_ext
			assign sel.levels[i] = ext_priority_levels[3*i +: `VIC_LVL_W];
		end
		assign lose_err[i] = sel.win_valid && sel.active[i] && (sel.levels[i] < sel.win_level
			|| (sel.levels[i] == sel.win_level && vic_pkg::src_t'(i) < sel.win_id));
	end

	assign sel.active = irq_source_active;

	// ======================================================================
	// Arbitration against the level in service
	// ======================================================================
	// A winner only interrupts a running handler when strictly more urgent.
	assign eligible = sel.win_valid && (!sel.svc_busy || sel.win_level < sel.svc_level);

	assign addr_ok     = hsel && htrans[1] && hready;
	assign addr_sel    = decode(haddr);
	assign vec_rd      = addr_ok && !hwrite && addr_sel == vic_pkg::SEL_VEC;
	assign unused_size = hsize;
	assign stat_rd     = addr_ok && !hwrite && addr_sel == vic_pkg::SEL_STATUS;
	assign mask_wr     = s_reg.dp_write && s_reg.dp_sel == vic_pkg::SEL_MASK;

	// ======================================================================
	// Register file and AHB-Lite slave
	// ======================================================================
	// Writes land in the data phase and are applied before the read mux, so a
	// read right behind a write to the same register sees the new value.
	always_comb begin
		s_next       = s_reg;
		events       = '0;
		rd_clear     = '0;
		sel.push       = 1'b0;
		sel.push_level = sel.win_level;
		sel.pop        = 1'b0;
		if (s_reg.dp_write) begin
			case (s_reg.dp_sel)
				vic_pkg::SEL_BASE:        s_next.vec_base = hwdata[`VIC_BASE_W-1:0];
				vic_pkg::SEL_PRIO_FIRST:  s_next.prio_first = hwdata & `VIC_FIRST_FIELD_MASK;
				vic_pkg::SEL_PRIO_SECOND: s_next.prio_second = hwdata & `VIC_SECOND_FIELD_MASK;
				vic_pkg::SEL_CFG:         s_next.cfg_en = hwdata[`VIC_CFG_EN_BIT];
				vic_pkg::SEL_MASK:        s_next.mask = hwdata[`VIC_EV_W-1:0];
				vic_pkg::SEL_EOI: begin
					sel.pop                = 1'b1;
					events[`VIC_EV_UNDER]  = !sel.svc_busy;
				end
				default: ;
			endcase
		end
		s_next.dp_write = addr_ok && hwrite;
		s_next.dp_sel   = addr_ok ? addr_sel : vic_pkg::SEL_NONE;
		if (addr_ok && !hwrite) begin
			case (addr_sel)
				vic_pkg::SEL_BASE:        s_next.hrdata = {16'h0000, s_next.vec_base};
				vic_pkg::SEL_VEC: begin
					s_next.hrdata = {9'h000, s_next.vec_base, sel.win_id, 2'h0};
					// The read is the core's acknowledge: it opens a nesting level.
					if (s_reg.cfg_en && eligible) begin
						sel.push            = 1'b1;
						events[`VIC_EV_ACK] = 1'b1;
					end
				end
				vic_pkg::SEL_PRIO_FIRST:  s_next.hrdata = s_next.prio_first;
				vic_pkg::SEL_PRIO_SECOND: s_next.hrdata = s_next.prio_second;
				vic_pkg::SEL_CFG:         s_next.hrdata = {31'h00000000, s_next.cfg_en};
				vic_pkg::SEL_STATUS: begin
					s_next.hrdata = {29'h00000000, s_reg.status};
					rd_clear      = '1;
				end
				vic_pkg::SEL_MASK:        s_next.hrdata = {29'h00000000, s_next.mask};
				default:                  s_next.hrdata = 32'h00000000;
			endcase
		end
		events[`VIC_EV_WIN] = s_reg.cfg_en && eligible && !s_reg.elig_d;
		// Events that coincide with the clearing read stay set.
		s_next.status   = (s_reg.status & ~rd_clear) | events;
		s_next.irq_line = |(s_next.status & s_next.mask);
		s_next.elig_d   = eligible;
		// Without vectoring the core sees a plain OR of the active sources.
		s_next.irq_req  = s_reg.cfg_en ? eligible : |irq_source_active;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg             <= '0;
			s_reg.vec_base    <= `VIC_BASE_RESET;
			s_reg.prio_first  <= `VIC_PRIO_RESET;
			s_reg.prio_second <= `VIC_PRIO_RESET;
			s_reg.dp_sel      <= vic_pkg::SEL_NONE;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hreadyout     = 1'b1;
	assign hresp         = 1'b0;
	assign hrdata        = s_reg.hrdata;
	assign irq_request   = s_reg.irq_req;
	assign irq_interrupt = s_reg.irq_line;

	// ======================================================================
	// Assertions
	// ======================================================================
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence seq_vec_read;
		vec_rd && !s_reg.dp_write;
	endsequence

	sequence seq_vec_take;
		vec_rd && s_reg.cfg_en && eligible;
	endsequence

	sequence seq_eoi_write;
		s_reg.dp_write && s_reg.dp_sel == vic_pkg::SEL_EOI;
	endsequence

	property p_vec_layout;
		seq_vec_read |=> hrdata[31:23] == 9'h000 && hrdata[1:0] == 2'h0
			&& hrdata[22:7] == $past(s_reg.vec_base) && hrdata[6:2] == $past(sel.win_id);
	endproperty

	property p_vec_range;
		seq_vec_read |=> hrdata[6:2] <= `VIC_LAST_SRC_ID;
	endproperty

	property p_nest_push;
		seq_vec_take |=> sel.svc_busy && sel.svc_level == $past(sel.win_level) && s_reg.status[`VIC_EV_ACK];
	endproperty

	property p_underflow;
		seq_eoi_write ##0 !sel.svc_busy |=> s_reg.status[`VIC_EV_UNDER];
	endproperty

	sequence seq_line_held;
		|(s_reg.status & s_reg.mask) && !stat_rd && !mask_wr;
	endsequence

	sequence seq_vec_plain;
		vec_rd && !s_reg.cfg_en && !sel.pop;
	endsequence

	sequence seq_eoi_busy;
		seq_eoi_write ##0 (sel.svc_busy && !sel.push);
	endsequence

	property p_eoi_pop;
		seq_eoi_busy |=> !sel.svc_busy || sel.svc_level > $past(sel.svc_level);
	endproperty

	property p_plain_no_nest;
		seq_vec_plain |=> sel.svc_busy == $past(sel.svc_busy) && sel.svc_level == $past(sel.svc_level);
	endproperty

	property p_status_clear;
		stat_rd |=> s_reg.status == $past(events);
	endproperty

	AST_VEC_LAYOUT: assert property (p_vec_layout) else $error("vector word layout wrong");
	AST_VEC_RANGE: assert property (p_vec_range) else $error("source number above 27");
	AST_TIMER_TWO: assert property (sel.win_valid && sel.win_id == `VIC_TIMER_TWO_SRC
		|-> sel.win_level == s_reg.prio_first[14:12]) else $error("second timer level misrouted");
	AST_FIRST_RSV: assert property ((s_reg.prio_first & ~`VIC_FIRST_FIELD_MASK) == 32'h00000000)
		else $error("reserved bits set in first priority register");
	AST_SECOND_RSV: assert property ((s_reg.prio_second & ~`VIC_SECOND_FIELD_MASK) == 32'h00000000)
		else $error("reserved bits set in second priority register");
	AST_PLAIN_MODE: assert property (!s_reg.cfg_en |=> irq_request == $past(|irq_source_active))
		else $error("plain request does not follow sources");
	AST_TIEBREAK: assert property (lose_err == '0 && sel.win_valid == |irq_source_active)
		else $error("arbitration picked the wrong source");
	AST_NEST_PUSH: assert property (p_nest_push) else $error("nesting level not opened");
	AST_BASE_UPPER: assert property (addr_ok && !hwrite && addr_sel == vic_pkg::SEL_BASE
		|=> hrdata[31:16] == 16'h0000) else $error("base upper half not zero");
	AST_UNDERFLOW: assert property (p_underflow) else $error("spurious end of service not flagged");
	AST_IRQ_LINE: assert property (seq_line_held |=> irq_interrupt)
		else $error("interrupt line low with unmasked event");

	// ======================================================================
	// Field routing
	// ======================================================================
	// Fixed bit ranges here, independent of the stride arithmetic that builds
	// the level vector, so a field shifted by one slot is caught.
	AST_FLASH_LEVELS: assert property (
		sel.levels[8] == s_reg.prio_first[30:28] && sel.levels[7] == s_reg.prio_first[26:24])
		else $error("flash levels misrouted");
	AST_TIMER_HIGH: assert property (
		sel.levels[6] == s_reg.prio_first[22:20] && sel.levels[5] == s_reg.prio_first[18:16])
		else $error("third or fourth timer level misrouted");
	AST_TIMER_LOW: assert property (
		sel.levels[4] == s_reg.prio_first[14:12] && sel.levels[3] == s_reg.prio_first[10:8])
		else $error("first or second timer level misrouted");
	AST_SOFT_LEVEL: assert property (
		sel.levels[2] == s_reg.prio_first[6:4])
		else $error("software interrupt level misrouted");
	AST_SRC_ZERO: assert property (
		sel.levels[0] == 3'h0 && s_reg.prio_first[3:0] == 4'h0)
		else $error("source 0 has a level");
	AST_I2C_SECOND: assert property (
		sel.levels[16] == s_reg.prio_second[30:28] && sel.levels[15] == s_reg.prio_second[26:24])
		else $error("second bus controller levels misrouted");
	AST_I2C_FIRST: assert property (
		sel.levels[14] == s_reg.prio_second[22:20] && sel.levels[13] == s_reg.prio_second[18:16])
		else $error("first bus controller levels misrouted");
	AST_SYNTH_LEVEL: assert property (
		sel.levels[12] == s_reg.prio_second[14:12])
		else $error("synthesizer lock level misrouted");
	AST_SERIAL_LEVELS: assert property (
		sel.levels[11] == s_reg.prio_second[10:8] && sel.levels[10] == s_reg.prio_second[6:4])
		else $error("serial levels misrouted");
	AST_CONV_LEVEL: assert property (
		sel.levels[9] == s_reg.prio_second[2:0])
		else $error("converter level misrouted");

	// ======================================================================
	// Request and nesting
	// ======================================================================
	AST_VEC_REQ: assert property (
		s_reg.cfg_en |=> irq_request == $past(eligible))
		else $error("vectored request does not follow eligibility");
	AST_PLAIN_NO_NEST: assert property (
		p_plain_no_nest)
		else $error("vector read changed nesting with vectoring off");
	// A handler of equal or lower urgency must never pre-empt the one running.
	AST_NEST_BLOCK: assert property (
		s_reg.cfg_en && sel.svc_busy && sel.win_level >= sel.svc_level |=> !irq_request)
		else $error("request raised against a more urgent handler");
	AST_EOI_POP: assert property (
		p_eoi_pop)
		else $error("end of service did not release the most urgent level");
	AST_BASE_READ: assert property (
		addr_ok && !hwrite && addr_sel == vic_pkg::SEL_BASE && !s_reg.dp_write
		|=> hrdata[15:0] == $past(s_reg.vec_base))
		else $error("base read value wrong");
	AST_VEC_IDLE: assert property (
		seq_vec_read ##0 !sel.win_valid |=> hrdata[6:2] == 5'h00)
		else $error("source field not zero with no source active");
	// Read-to-clear keeps only what arrived in the clearing cycle itself.
	AST_STATUS_CLEAR: assert property (
		p_status_clear)
		else $error("status read did not clear");
endmodule

`default_nettype wire

// *** sim/core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "vic_defs.svh"

module core_model (
	input  wire logic        hclk,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	input  wire logic        irq_request
);
	logic vec_on;

	initial begin
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		vec_on = 1'h0;
	end

	// ==========================================================================
	// Single word transfers
	// ==========================================================================
	// Called right after a rising edge; returns at the edge that ends the data phase.
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		// Stale write data is inverted so that a slave sampling it too early shows up.
		hwdata <= ~hwdata;
		do @(posedge hclk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'h1);
		q = hrdata;
	endtask

	task automatic write32(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		if (a == `VIC_ADDR_CFG) begin
			vec_on = d[`VIC_CFG_EN_BIT];
		end
		xfer(1'h1, a, d, q);
	endtask

	task automatic read32(input logic [31:0] a, output logic [31:0] q);
		xfer(1'h0, a, 32'h0, q);
	endtask

	// Software only fetches the vector while an IRQ is pending with vectoring on.
	task automatic read_vec(output logic [31:0] q);
		if (vec_on && irq_request === 1'h1) begin
			xfer(1'h0, `VIC_ADDR_VEC, 32'h0, q);
		end else begin
			q = 32'hFFFFFFFF;
		end
	endtask
endmodule

`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "vic_defs.svh"

module tb;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic        hwrite;
	logic        hreadyout;
	logic        hresp;
	logic        irq_request;
	logic        irq_interrupt;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [27:0] irq_source_active;
	logic [83:0] ext_priority_levels;
	int          err_count;
	int          samples_checked;
	int          cycles;

	localparam logic [27:0] arb_mask [20] = '{28'h000001C, 28'h0000300, 28'h0000101, 28'h8000000,
		28'h0000240, 28'h0008040, 28'h0004020, 28'h0002010, 28'h0001008, 28'h0000804, 28'h0010080,
		28'h8000400, 28'h0008100, 28'h0004080, 28'h0002040, 28'h0001020, 28'h0000810, 28'h0000408,
		28'h8000004, 28'h0020002};
	localparam logic [4:0] arb_id [20] = '{5'h04, 5'h08, 5'h00, 5'h1B, 5'h09, 5'h0F, 5'h0E, 5'h0D,
		5'h0C, 5'h0B, 5'h10, 5'h0A, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01};

	irq_vector_priority_unit u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_source_active(irq_source_active),
		.ext_priority_levels(ext_priority_levels), .irq_request(irq_request), .irq_interrupt(irq_interrupt));

	core_model u_core (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .irq_request(irq_request));

	initial hclk = 1'h0;
	always #5 hclk = ~hclk;

	// ==========================================================================
	// Helpers
	// ==========================================================================
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		u_core.write32(a, d);
	endtask

	task automatic rd_check(input string name, input logic [31:0] a, input logic [31:0] exp);
		u_core.read32(a, q);
		check(name, q, exp);
	endtask

	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ==========================================================================
	// Scenarios
	// ==========================================================================
	task automatic t_reset;
		rd_check("prio first reset", `VIC_ADDR_PRIO_FIRST, 32'h0);
		rd_check("prio second reset", `VIC_ADDR_PRIO_SECOND, 32'h0);
		rd_check("base reset", `VIC_ADDR_BASE, 32'h0);
		rd_check("vector reset", `VIC_ADDR_VEC, 32'h0);
	endtask

	// Distinct nibbles prove each field lands in its own slot and reserved bits drop out.
	task automatic t_regs;
		wr(`VIC_ADDR_PRIO_FIRST, 32'h12345678);
		wr(`VIC_ADDR_PRIO_SECOND, 32'h9ABCDEF1);
		wr(`VIC_ADDR_BASE, 32'hFFFFFFFF);
		wr(`VIC_ADDR_VEC, 32'hFFFFFFFF);
		wr(32'hFFFF0040, 32'hFFFFFFFF);
		check("hresp okay", {31'h0, hresp}, 32'h0);
		rd_check("prio first", `VIC_ADDR_PRIO_FIRST, 32'h12345670);
		rd_check("prio second", `VIC_ADDR_PRIO_SECOND, 32'h12345671);
		rd_check("base", `VIC_ADDR_BASE, 32'h0000FFFF);
		rd_check("vector idle", `VIC_ADDR_VEC, 32'h007FFF80);
		rd_check("unmapped", 32'hFFFF0040, 32'h0);
	endtask

	task automatic t_arb;
		wr(`VIC_ADDR_CFG, 32'h1);
		wr(`VIC_ADDR_BASE, 32'h0000A5C3);
		for (int i = 0; i < 20; i++) begin
			irq_source_active <= arb_mask[i];
			idle(3);
			u_core.read_vec(q);
			check("vector winner", q, {9'h000, 16'hA5C3, arb_id[i], 2'h0});
			idle(2);
			check("same level blocked", {31'h0, irq_request}, 32'h0);
			irq_source_active <= 28'h0;
			wr(`VIC_ADDR_EOI, 32'h0);
			idle(3);
		end
	endtask

	// Sources 17 to 24 get levels 7 down to 0 so each new one pre-empts the last.
	task automatic t_nest;
		logic [83:0] lv;
		lv = ext_priority_levels;
		for (int k = 0; k < 8; k++) begin
			lv[3*(17+k) +: 3] = 3'(7 - k);
		end
		ext_priority_levels <= lv;
		for (int k = 0; k < 8; k++) begin
			irq_source_active[17+k] <= 1'h1;
			idle(3);
			check("nest request", {31'h0, irq_request}, 32'h1);
			u_core.read_vec(q);
			check("nest vector", q, {9'h000, 16'hA5C3, 5'(17 + k), 2'h0});
			idle(2);
		end
		check("all levels busy", {31'h0, irq_request}, 32'h0);
		irq_source_active <= 28'h0;
		repeat (8) wr(`VIC_ADDR_EOI, 32'h0);
	endtask

	task automatic t_cfg_off;
		wr(`VIC_ADDR_CFG, 32'h0);
		irq_source_active <= 28'h0000020;
		idle(3);
		check("plain request", {31'h0, irq_request}, 32'h1);
		u_core.read32(`VIC_ADDR_VEC, q);
		idle(2);
		check("no nesting when off", {31'h0, irq_request}, 32'h1);
		irq_source_active <= 28'h0;
		idle(3);
		check("request drops", {31'h0, irq_request}, 32'h0);
	endtask

	task automatic t_irq;
		u_core.read32(`VIC_ADDR_STATUS, q);
		wr(`VIC_ADDR_MASK, 32'h4);
		rd_check("mask", `VIC_ADDR_MASK, 32'h4);
		wr(`VIC_ADDR_EOI, 32'h0);
		idle(3);
		check("irq raised", {31'h0, irq_interrupt}, 32'h1);
		rd_check("status", `VIC_ADDR_STATUS, 32'h4);
		idle(3);
		check("irq cleared", {31'h0, irq_interrupt}, 32'h0);
		wr(`VIC_ADDR_MASK, 32'h0);
		wr(`VIC_ADDR_EOI, 32'h0);
		idle(3);
		check("irq masked", {31'h0, irq_interrupt}, 32'h0);
		rd_check("status masked", `VIC_ADDR_STATUS, 32'h4);
	endtask

	// ==========================================================================
	// Main sequence and hang guard
	// ==========================================================================
	always @(posedge hclk) begin
		cycles = cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			results();
		end
	end

	initial begin
		err_count = 0;
		samples_checked = 0;
		cycles = 0;
		hresetn = 1'h0;
		irq_source_active = 28'h0;
		ext_priority_levels = {28{3'h7}};
		idle(6);
		hresetn <= 1'h1;
		t_reset();
		t_regs();
		t_arb();
		t_nest();
		t_cfg_off();
		t_irq();
		results();
	end
endmodule

`default_nettype wire
